// ---- ecc_inject_regs.svh ----
// register offsets, field positions and reset values of the ecc injector
`ifndef ECC_INJECT_REGS_SVH
`define ECC_INJECT_REGS_SVH

`define ADDR_W              12
`define OFS_FIFO_TRIG       12'h354
`define OFS_TX_DATA_LOW     12'h358
`define OFS_TX_DATA_MID     12'h35C
`define OFS_TX_DATA_TOP     12'h360
`define OFS_TX_CTRL         12'h364
`define OFS_RX_DATA_LOW     12'h368
`define OFS_RX_DATA_MID     12'h36C
`define OFS_RX_DATA_TOP     12'h370
`define OFS_RX_CTRL         12'h374
`define OFS_PCS_TRIG        12'h37C
`define OFS_LANE0           12'h380
`define OFS_LANE1           12'h384

`define DATA_CW_W           72
`define CTRL_CW_W           13
`define LANE_CW_W           28
`define TOP_W               8
`define FIFO_TRIG_W         4
`define PCS_TRIG_W          6

`define FT_TX_DATA          0
`define FT_TX_CTRL          1
`define FT_RX_DATA          2
`define FT_RX_CTRL          3
`define PT_LANE0            0
`define PT_LANE1            1
`define PT_LANE2            2
`define PT_LANE3            3
`define PT_RATE_DATA        4
`define PT_RATE_CTRL        5

`define RST_ZERO            32'h0000_0000

`endif

// ---- ecc_inject_pkg.sv ----
// codeword types shared by the ecc injector
package ecc_inject_pkg;
    typedef logic [71:0] data_cw_t;
    typedef logic [12:0] ctrl_cw_t;
    typedef logic [27:0] lane_cw_t;
endpackage : ecc_inject_pkg

// ---- ecc_error_injection_masks.sv ----
// apb-reached error injection masks and triggers for secded memories
`timescale 1ns/10ps
`include "ecc_inject_regs.svh"

// Operation
// - tx data mid mask flips tx codeword bits 63 to 32
// - tx data top mask bits 7:0 flip tx bits 71:64; rest reserved
// - tx control mask uses 13 low bits, one per control+check bit
// - rx data low mask flips rx codeword bits 31 to 0
// - rx data mid mask bit n flips rx codeword bit n+32
// - rx data top mask bits 7:0 flip rx bits 71:64; rest reserved
// - rx control mask holds 13 bits for rx control+check word
// - pcs trigger bit 5 requests rate control error, then self-clears
// - pcs trigger bit 4 requests rate data error, then self-clears
// - pcs trigger bits 3:0 request lane errors, self-clear; 31:6 reserved
// - lane 0 mask holds 28 bits in 27:0; top four reserved
// - lane 1 mask holds 28 bits in 27:0; top four reserved
// - mask one corrupts its codeword bit, zero leaves it alone
// - tx data low mask flips tx codeword bits 31 to 0
// - fifo trigger bits 0..3 request tx/rx data/control errors, self-clear
// - registers exist only with protected memories and mac present
module ecc_error_injection_masks
    import ecc_inject_pkg::*;
#(
    parameter bit ECC_RAMS_ON = 1'b1,
    parameter bit MAC_PRESENT = 1'b1
)
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`ADDR_W-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire data_cw_t              tx_data_in,
    input  wire logic                  tx_data_wen,
    output data_cw_t                   tx_data_out,
    output logic                       tx_data_wen_out,
    input  wire ctrl_cw_t              tx_ctrl_in,
    input  wire logic                  tx_ctrl_wen,
    output ctrl_cw_t                   tx_ctrl_out,
    output logic                       tx_ctrl_wen_out,
    input  wire data_cw_t              rx_data_in,
    input  wire logic                  rx_data_wen,
    output data_cw_t                   rx_data_out,
    output logic                       rx_data_wen_out,
    input  wire ctrl_cw_t              rx_ctrl_in,
    input  wire logic                  rx_ctrl_wen,
    output ctrl_cw_t                   rx_ctrl_out,
    output logic                       rx_ctrl_wen_out,
    input  wire lane_cw_t              lane0_in,
    input  wire logic                  lane0_wen,
    output lane_cw_t                   lane0_out,
    output logic                       lane0_wen_out,
    input  wire lane_cw_t              lane1_in,
    input  wire logic                  lane1_wen,
    output lane_cw_t                   lane1_out,
    output logic                       lane1_wen_out,
    input  wire logic                  lane2_wen,
    input  wire logic                  lane3_wen,
    input  wire logic                  rate_data_wen,
    input  wire logic                  rate_ctrl_wen,
    output logic                       lane2_inject_req,
    output logic                       lane3_inject_req,
    output logic                       rate_data_inject_req,
    output logic                       rate_ctrl_inject_req
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // xor of a mask into a codeword only while the request stands
    function automatic data_cw_t flip_data(
        input data_cw_t cw,
        input data_cw_t mask,
        input logic     req
    );
        flip_data = req ? (cw ^ mask) : cw;
    endfunction : flip_data

    function automatic ctrl_cw_t flip_ctrl(
        input ctrl_cw_t cw,
        input ctrl_cw_t mask,
        input logic     req
    );
        flip_ctrl = req ? (cw ^ mask) : cw;
    endfunction : flip_ctrl

    function automatic lane_cw_t flip_lane(
        input lane_cw_t cw,
        input lane_cw_t mask,
        input logic     req
    );
        flip_lane = req ? (cw ^ mask) : cw;
    endfunction : flip_lane

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [31:0]              tx_data_mask_low_r;
    logic [31:0]              tx_data_mask_mid_r;
    logic [`TOP_W-1:0]        tx_data_mask_top_r;
    logic [`CTRL_CW_W-1:0]    tx_fifo_ctrl_mask_r;
    logic [31:0]              rx_fifo_data_mask_low_r;
    logic [31:0]              rx_fifo_data_mask_mid_r;
    logic [`TOP_W-1:0]        rx_fifo_data_mask_top_r;
    logic [`CTRL_CW_W-1:0]    rx_fifo_ctrl_mask_r;
    logic [`LANE_CW_W-1:0]    deskew_lane0_mask_r;
    logic [`LANE_CW_W-1:0]    deskew_lane1_mask_r;
    logic [`FIFO_TRIG_W-1:0]  fifo_error_trigger_r;
    logic [`FIFO_TRIG_W-1:0]  fifo_error_trigger_nxt;
    logic [`PCS_TRIG_W-1:0]   pcs_error_trigger_r;
    logic [`PCS_TRIG_W-1:0]   pcs_error_trigger_nxt;
    logic [31:0]              prdata_r;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    // with the option off the whole window is unmapped
    wire present = ECC_RAMS_ON && MAC_PRESENT;

    wire hit_ftrig = present && (paddr == `OFS_FIFO_TRIG);
    wire hit_txl   = present && (paddr == `OFS_TX_DATA_LOW);
    wire hit_txm   = present && (paddr == `OFS_TX_DATA_MID);
    wire hit_txt   = present && (paddr == `OFS_TX_DATA_TOP);
    wire hit_txc   = present && (paddr == `OFS_TX_CTRL);
    wire hit_rxl   = present && (paddr == `OFS_RX_DATA_LOW);
    wire hit_rxm   = present && (paddr == `OFS_RX_DATA_MID);
    wire hit_rxt   = present && (paddr == `OFS_RX_DATA_TOP);
    wire hit_rxc   = present && (paddr == `OFS_RX_CTRL);
    wire hit_ptrig = present && (paddr == `OFS_PCS_TRIG);
    wire hit_ln0   = present && (paddr == `OFS_LANE0);
    wire hit_ln1   = present && (paddr == `OFS_LANE1);

    wire hit_any = hit_ftrig | hit_txl | hit_txm | hit_txt | hit_txc
                 | hit_rxl | hit_rxm | hit_rxt | hit_rxc
                 | hit_ptrig | hit_ln0 | hit_ln1;

    wire setup_ph = psel && !penable;
    wire access   = psel && penable;
    wire wr_en    = access && pwrite && hit_any;

    // reserved bits pad with zero so they always read back as zero
    wire [31:0] rd_mux =
          ({32{hit_ftrig}} & {28'h0, fifo_error_trigger_r})
        | ({32{hit_txl}}   & tx_data_mask_low_r)
        | ({32{hit_txm}}   & tx_data_mask_mid_r)
        | ({32{hit_txt}}   & {24'h0, tx_data_mask_top_r})
        | ({32{hit_txc}}   & {19'h0, tx_fifo_ctrl_mask_r})
        | ({32{hit_rxl}}   & rx_fifo_data_mask_low_r)
        | ({32{hit_rxm}}   & rx_fifo_data_mask_mid_r)
        | ({32{hit_rxt}}   & {24'h0, rx_fifo_data_mask_top_r})
        | ({32{hit_rxc}}   & {19'h0, rx_fifo_ctrl_mask_r})
        | ({32{hit_ptrig}} & {26'h0, pcs_error_trigger_r})
        | ({32{hit_ln0}}   & {4'h0, deskew_lane0_mask_r})
        | ({32{hit_ln1}}   & {4'h0, deskew_lane1_mask_r});

    // read data is caught in setup so it comes from a flop in access
    assign pready  = 1'b1;
    assign pslverr = access && !hit_any;
    assign prdata  = prdata_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= `RST_ZERO;
        else if (setup_ph)
            prdata_r <= pwrite ? `RST_ZERO : rd_mux;
    end

    // ------------------------------------------------------------------
    // mask registers
    // ------------------------------------------------------------------
    // masks are never touched by an injection, only by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_data_mask_low_r      <= `RST_ZERO;
            tx_data_mask_mid_r      <= `RST_ZERO;
            tx_data_mask_top_r      <= `TOP_W'(`RST_ZERO);
            tx_fifo_ctrl_mask_r     <= `CTRL_CW_W'(`RST_ZERO);
            rx_fifo_data_mask_low_r <= `RST_ZERO;
            rx_fifo_data_mask_mid_r <= `RST_ZERO;
            rx_fifo_data_mask_top_r <= `TOP_W'(`RST_ZERO);
            rx_fifo_ctrl_mask_r     <= `CTRL_CW_W'(`RST_ZERO);
            deskew_lane0_mask_r     <= `LANE_CW_W'(`RST_ZERO);
            deskew_lane1_mask_r     <= `LANE_CW_W'(`RST_ZERO);
        end
        else if (wr_en)
        begin
            if (hit_txl)
                tx_data_mask_low_r <= pwdata;
            if (hit_txm)
                tx_data_mask_mid_r <= pwdata;
            if (hit_txt)
                tx_data_mask_top_r <= pwdata[`TOP_W-1:0];
            if (hit_txc)
                tx_fifo_ctrl_mask_r <= pwdata[`CTRL_CW_W-1:0];
            if (hit_rxl)
                rx_fifo_data_mask_low_r <= pwdata;
            if (hit_rxm)
                rx_fifo_data_mask_mid_r <= pwdata;
            if (hit_rxt)
                rx_fifo_data_mask_top_r <= pwdata[`TOP_W-1:0];
            if (hit_rxc)
                rx_fifo_ctrl_mask_r <= pwdata[`CTRL_CW_W-1:0];
            if (hit_ln0)
                deskew_lane0_mask_r <= pwdata[`LANE_CW_W-1:0];
            if (hit_ln1)
                deskew_lane1_mask_r <= pwdata[`LANE_CW_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // trigger registers
    // ------------------------------------------------------------------
    // a write of one sets a request, a zero is ignored; a request is
    // consumed by the next write into its memory; software set wins
    // over a consume in the same cycle so a fresh request is not lost
    wire [`FIFO_TRIG_W-1:0] fifo_consume = {rx_ctrl_wen, rx_data_wen,
                                            tx_ctrl_wen, tx_data_wen};
    wire [`PCS_TRIG_W-1:0]  pcs_consume  = {rate_ctrl_wen, rate_data_wen,
                                            lane3_wen, lane2_wen,
                                            lane1_wen, lane0_wen};
    wire [`FIFO_TRIG_W-1:0] fifo_set =
        (wr_en && hit_ftrig) ? pwdata[`FIFO_TRIG_W-1:0] : '0;
    wire [`PCS_TRIG_W-1:0]  pcs_set =
        (wr_en && hit_ptrig) ? pwdata[`PCS_TRIG_W-1:0] : '0;

    assign fifo_error_trigger_nxt =
        (fifo_error_trigger_r & ~fifo_consume) | fifo_set;
    assign pcs_error_trigger_nxt =
        (pcs_error_trigger_r & ~pcs_consume) | pcs_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_error_trigger_r <= `FIFO_TRIG_W'(`RST_ZERO);
            pcs_error_trigger_r  <= `PCS_TRIG_W'(`RST_ZERO);
        end
        else
        begin
            fifo_error_trigger_r <= fifo_error_trigger_nxt;
            pcs_error_trigger_r  <= pcs_error_trigger_nxt;
        end
    end

    // ------------------------------------------------------------------
    // write-path corruption
    // ------------------------------------------------------------------
    wire data_cw_t tx_data_mask = {tx_data_mask_top_r,
                                   tx_data_mask_mid_r,
                                   tx_data_mask_low_r};
    wire data_cw_t rx_data_mask = {rx_fifo_data_mask_top_r,
                                   rx_fifo_data_mask_mid_r,
                                   rx_fifo_data_mask_low_r};

    wire inj_txd = fifo_error_trigger_r[`FT_TX_DATA];
    wire inj_txc = fifo_error_trigger_r[`FT_TX_CTRL];
    wire inj_rxd = fifo_error_trigger_r[`FT_RX_DATA];
    wire inj_rxc = fifo_error_trigger_r[`FT_RX_CTRL];
    wire inj_ln0 = pcs_error_trigger_r[`PT_LANE0];
    wire inj_ln1 = pcs_error_trigger_r[`PT_LANE1];

    // one cycle of latency on every path keeps the outputs on flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_data_out     <= '0;
            tx_data_wen_out <= 1'b0;
            tx_ctrl_out     <= '0;
            tx_ctrl_wen_out <= 1'b0;
            rx_data_out     <= '0;
            rx_data_wen_out <= 1'b0;
            rx_ctrl_out     <= '0;
            rx_ctrl_wen_out <= 1'b0;
        end
        else
        begin
            tx_data_wen_out <= tx_data_wen;
            tx_ctrl_wen_out <= tx_ctrl_wen;
            rx_data_wen_out <= rx_data_wen;
            rx_ctrl_wen_out <= rx_ctrl_wen;
            if (tx_data_wen)
                tx_data_out <= flip_data(tx_data_in, tx_data_mask,
                                         inj_txd);
            if (tx_ctrl_wen)
                tx_ctrl_out <= flip_ctrl(tx_ctrl_in, tx_fifo_ctrl_mask_r,
                                         inj_txc);
            if (rx_data_wen)
                rx_data_out <= flip_data(rx_data_in, rx_data_mask,
                                         inj_rxd);
            if (rx_ctrl_wen)
                rx_ctrl_out <= flip_ctrl(rx_ctrl_in, rx_fifo_ctrl_mask_r,
                                         inj_rxc);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lane0_out     <= '0;
            lane0_wen_out <= 1'b0;
            lane1_out     <= '0;
            lane1_wen_out <= 1'b0;
        end
        else
        begin
            lane0_wen_out <= lane0_wen;
            lane1_wen_out <= lane1_wen;
            if (lane0_wen)
                lane0_out <= flip_lane(lane0_in, deskew_lane0_mask_r,
                                       inj_ln0);
            if (lane1_wen)
                lane1_out <= flip_lane(lane1_in, deskew_lane1_mask_r,
                                       inj_ln1);
        end
    end

    // ------------------------------------------------------------------
    // requests for paths whose masks live outside this block
    // ------------------------------------------------------------------
    // the owner applies its own mask on its next write, which also
    // clears the request above
    assign lane2_inject_req     = pcs_error_trigger_r[`PT_LANE2];
    assign lane3_inject_req     = pcs_error_trigger_r[`PT_LANE3];
    assign rate_data_inject_req =
        pcs_error_trigger_r[`PT_RATE_DATA];
    assign rate_ctrl_inject_req =
        pcs_error_trigger_r[`PT_RATE_CTRL];

endmodule : ecc_error_injection_masks

// ---- ecc_error_injection_masks_asserts.sv ----
// concurrent checks on the ports of the ecc error injector
`timescale 1ns/10ps
`include "ecc_inject_regs.svh"

module ecc_error_injection_masks_asserts
    import ecc_inject_pkg::*;
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pslverr,
    input wire logic               tx_data_wen,
    input wire logic               tx_data_wen_out,
    input wire logic               tx_ctrl_wen,
    input wire ctrl_cw_t           tx_ctrl_out,
    input wire logic               lane2_wen,
    input wire logic               lane3_wen,
    input wire logic               rate_data_wen,
    input wire logic               rate_ctrl_wen,
    input wire logic               lane2_inject_req,
    input wire logic               lane3_inject_req,
    input wire logic               rate_data_inject_req,
    input wire logic               rate_ctrl_inject_req
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire pcs_wr_w = psel && penable && pwrite && paddr == `OFS_PCS_TRIG;

    sequence pcs_wr_s;
        psel && penable && pwrite && paddr == `OFS_PCS_TRIG;
    endsequence

    // a software set in the consuming cycle wins, so it is excluded
    property consume_p(req, wen, set);
        req && wen && !set |=> !req;
    endproperty

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_tx_wen_latency: assert property (
        tx_data_wen |=> tx_data_wen_out) else $error("tx write not passed on");
    chk_tx_wen_single: assert property (
        !tx_data_wen |=> !tx_data_wen_out) else $error("spurious tx write");
    chk_ctrl_out_hold: assert property (
        !tx_ctrl_wen |=> $stable(tx_ctrl_out)) else $error("tx ctrl moved");
    chk_lane2_consume: assert property (
        consume_p(lane2_inject_req, lane2_wen, pcs_wr_w && pwdata[2]))
        else $error("lane 2 request not cleared");
    chk_lane3_hold: assert property (
        lane3_inject_req && !lane3_wen |=> lane3_inject_req)
        else $error("lane 3 request lost");
    chk_rate_data_consume: assert property (
        consume_p(rate_data_inject_req, rate_data_wen, pcs_wr_w && pwdata[4]))
        else $error("rate data request not cleared");
    chk_rate_ctrl_consume: assert property (
        consume_p(rate_ctrl_inject_req, rate_ctrl_wen, pcs_wr_w && pwdata[5]))
        else $error("rate ctrl request not cleared");
    chk_rate_ctrl_set: assert property (
        pcs_wr_s ##0 pwdata[5] |=> rate_ctrl_inject_req)
        else $error("rate ctrl request not set");
    chk_unmapped_refuse: assert property (
        psel && penable && paddr == 12'h378 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule : ecc_error_injection_masks_asserts

bind ecc_error_injection_masks ecc_error_injection_masks_asserts chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .tx_data_wen(tx_data_wen),
    .tx_data_wen_out(tx_data_wen_out), .tx_ctrl_wen(tx_ctrl_wen),
    .tx_ctrl_out(tx_ctrl_out), .lane2_wen(lane2_wen), .lane3_wen(lane3_wen),
    .rate_data_wen(rate_data_wen), .rate_ctrl_wen(rate_ctrl_wen),
    .lane2_inject_req(lane2_inject_req), .lane3_inject_req(lane3_inject_req),
    .rate_data_inject_req(rate_data_inject_req),
    .rate_ctrl_inject_req(rate_ctrl_inject_req));

// ---- tb_top.sv ----
// self-checking testbench of the ecc error injector
`timescale 1ns/10ps
`include "ecc_inject_regs.svh"

module tb_top
    import ecc_inject_pkg::*;
;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               err;
    data_cw_t           tx_data_in, tx_data_out, rx_data_in, rx_data_out;
    ctrl_cw_t           tx_ctrl_in, tx_ctrl_out, rx_ctrl_in, rx_ctrl_out;
    lane_cw_t           lane0_in, lane0_out, lane1_in, lane1_out;
    logic               tx_data_wen, tx_ctrl_wen, rx_data_wen, rx_ctrl_wen;
    logic               lane0_wen, lane1_wen, lane2_wen, lane3_wen;
    logic               rate_data_wen, rate_ctrl_wen;
    logic               tx_data_wen_out, tx_ctrl_wen_out, rx_data_wen_out;
    logic               rx_ctrl_wen_out, lane0_wen_out, lane1_wen_out;
    logic               lane2_inject_req, lane3_inject_req;
    logic               rate_data_inject_req, rate_ctrl_inject_req;
    int                 n_mismatch, tests_run;

    localparam data_cw_t din = 72'h5A_0123_4567_89AB_CDEF;
    localparam logic [11:0] addr_tab [12] = '{`OFS_TX_DATA_LOW,
        `OFS_TX_DATA_MID, `OFS_TX_DATA_TOP, `OFS_TX_CTRL, `OFS_RX_DATA_LOW,
        `OFS_RX_DATA_MID, `OFS_RX_DATA_TOP, `OFS_RX_CTRL, `OFS_LANE0,
        `OFS_LANE1, `OFS_FIFO_TRIG, `OFS_PCS_TRIG};
    localparam logic [31:0] wmask [10] = '{32'hFFFFFFFF, 32'hFFFFFFFF,
        32'hFF, 32'h1FFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFF, 32'h1FFF,
        32'h0FFFFFFF, 32'h0FFFFFFF};
    localparam logic [31:0] mval [10] = '{32'hA5A50F0F, 32'h12345678,
        32'hFFFFFF81, 32'hFFFF1ABC, 32'h00000001, 32'h80000000, 32'h0000017E,
        32'h00000001, 32'hF8000001, 32'h0FFFFFFF};

    ecc_error_injection_masks uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .tx_data_in(tx_data_in), .tx_data_wen(tx_data_wen),
        .tx_data_out(tx_data_out), .tx_data_wen_out(tx_data_wen_out),
        .tx_ctrl_in(tx_ctrl_in), .tx_ctrl_wen(tx_ctrl_wen),
        .tx_ctrl_out(tx_ctrl_out), .tx_ctrl_wen_out(tx_ctrl_wen_out),
        .rx_data_in(rx_data_in), .rx_data_wen(rx_data_wen),
        .rx_data_out(rx_data_out), .rx_data_wen_out(rx_data_wen_out),
        .rx_ctrl_in(rx_ctrl_in), .rx_ctrl_wen(rx_ctrl_wen),
        .rx_ctrl_out(rx_ctrl_out), .rx_ctrl_wen_out(rx_ctrl_wen_out),
        .lane0_in(lane0_in), .lane0_wen(lane0_wen), .lane0_out(lane0_out),
        .lane0_wen_out(lane0_wen_out), .lane1_in(lane1_in),
        .lane1_wen(lane1_wen), .lane1_out(lane1_out),
        .lane1_wen_out(lane1_wen_out), .lane2_wen(lane2_wen),
        .lane3_wen(lane3_wen), .rate_data_wen(rate_data_wen),
        .rate_ctrl_wen(rate_ctrl_wen), .lane2_inject_req(lane2_inject_req),
        .lane3_inject_req(lane3_inject_req),
        .rate_data_inject_req(rate_data_inject_req),
        .rate_ctrl_inject_req(rate_ctrl_inject_req));

    // ------------------------------------------------------------
    // clock, bus and compare tasks
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task check(input string what, input logic [71:0] seen,
               input logic [71:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // read data and the error flag are taken at the completing edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // one write strobe per path; the wens come back low after one cycle
    task pulse(input logic [9:0] w);
        @(posedge pclk);
        {rate_ctrl_wen, rate_data_wen, lane3_wen, lane2_wen, lane1_wen,
         lane0_wen, rx_ctrl_wen, rx_data_wen, tx_ctrl_wen, tx_data_wen} <= w;
        @(posedge pclk);
        {rate_ctrl_wen, rate_data_wen, lane3_wen, lane2_wen, lane1_wen,
         lane0_wen, rx_ctrl_wen, rx_data_wen, tx_ctrl_wen, tx_data_wen} <= '0;
        #1;
    endtask : pulse

    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_regs;
        for (int i = 0; i < 12; i++)
        begin
            apb(1'b0, addr_tab[i], 32'h0);
            check("reset value", rd, 72'h0);
            check("mapped flag", err, 72'h0);
        end
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b1, addr_tab[i], 32'hFFFFFFFF);
            apb(1'b0, addr_tab[i], 32'h0);
            check("mask width", rd, wmask[i]);
            apb(1'b1, addr_tab[i], mval[i]);
            apb(1'b0, addr_tab[i], 32'h0);
            check("mask value", rd, mval[i] & wmask[i]);
        end
        apb(1'b0, 12'h378, 32'h0);
        check("unmapped error", err, 72'h1);
        check("unmapped data", rd, 72'h0);
    endtask : t_regs

    task t_fifo;
        apb(1'b1, `OFS_FIFO_TRIG, 32'hFFFFFFFF);
        apb(1'b0, `OFS_FIFO_TRIG, 32'h0);
        check("fifo trigger", rd, 72'hF);
        pulse(10'h00F);
        check("tx data", tx_data_out, din ^ {8'h81, 32'h12345678, 32'hA5A50F0F});
        check("tx ctrl", tx_ctrl_out, 13'h0F0F ^ 13'h1ABC);
        check("rx data", rx_data_out, din ^ {8'h7E, 32'h80000000, 32'h1});
        check("rx ctrl", rx_ctrl_out, 13'h0F0F ^ 13'h1);
        check("fifo strobes", {tx_data_wen_out, tx_ctrl_wen_out, rx_data_wen_out, rx_ctrl_wen_out}, 72'hF);
        apb(1'b0, `OFS_FIFO_TRIG, 32'h0);
        check("fifo trigger cleared", rd, 72'h0);
        pulse(10'h00F);
        check("tx data clean", tx_data_out, din);
        check("rx ctrl clean", rx_ctrl_out, 13'h0F0F);
        apb(1'b0, `OFS_TX_DATA_MID, 32'h0);
        check("mask kept", rd, 72'h12345678);
    endtask : t_fifo

    task t_pcs;
        apb(1'b1, `OFS_PCS_TRIG, 32'hFFFFFFFF);
        apb(1'b0, `OFS_PCS_TRIG, 32'h0);
        check("pcs trigger", rd, 72'h3F);
        check("pcs requests", {rate_ctrl_inject_req, rate_data_inject_req, lane3_inject_req, lane2_inject_req}, 72'hF);
        pulse(10'h0F0);
        check("lane0", lane0_out, 28'h1234567 ^ 28'h8000001);
        check("lane1", lane1_out, 28'h1234567 ^ 28'hFFFFFFF);
        check("lane strobes", {lane0_wen_out, lane1_wen_out}, 72'h3);
        apb(1'b0, `OFS_PCS_TRIG, 32'h0);
        check("lanes consumed", rd, 72'h30);
        pulse(10'h100);
        apb(1'b0, `OFS_PCS_TRIG, 32'h0);
        check("rate data consumed", rd, 72'h20);
        pulse(10'h200);
        check("pcs requests off", {rate_ctrl_inject_req, rate_data_inject_req, lane3_inject_req, lane2_inject_req}, 72'h0);
        pulse(10'h010);
        check("lane0 clean", lane0_out, 28'h1234567);
    endtask : t_pcs

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rate_ctrl_wen, rate_data_wen, lane3_wen, lane2_wen, lane1_wen,
         lane0_wen, rx_ctrl_wen, rx_data_wen, tx_ctrl_wen, tx_data_wen} = '0;
        tx_data_in = din;
        rx_data_in = din;
        tx_ctrl_in = 13'h0F0F;
        rx_ctrl_in = 13'h0F0F;
        lane0_in = 28'h1234567;
        lane1_in = 28'h1234567;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_fifo();
        t_pcs();
        end_sim();
    end

    // the scenarios take well under a thousand cycles
    initial
    begin
        #(50 * 4000);
        n_mismatch++;
        end_sim();
    end
endmodule : tb_top
